// *** tb/sso_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sso_checker
  import sso_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        fwdTorqueLimitInN,
  input wire logic        fwdProhibitInN,
  input wire logic        revProhibitInN,
  input wire logic        faultDetect,
  input wire logic [11:0] motorSpeed,
  input wire logic        mainPowerOk,
  input wire logic        motorExcited,
  input wire logic        faultOut,
  input wire logic        rotationDetectOutN,
  input wire logic        readyOutN,
  input wire logic        overtravelOutN,
  input wire logic        excitationOutN,
  input wire logic        contactModeSwitch
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // pins need two sync stages, a flag and an output stage
  sequence noProhibit;
    (fwdProhibitInN && revProhibitInN) [*4];
  endsequence
  sequence torqueHeld;
    !fwdTorqueLimitInN [*4];
  endsequence
  a_fault_latch: assert property (faultDetect |-> ##2 faultOut)
    else $error("fault output not raised");
  a_ready_fault: assert property (faultDetect |-> ##3 readyOutN)
    else $error("ready kept during fault");
  a_ready_power: assert property (!mainPowerOk |-> ##2 readyOutN)
    else $error("ready kept without main power");
  // threshold never exceeds 3000, so these hold for any setting
  a_rotate_fast: assert property (motorSpeed > 12'hBB8 |-> ##2 !rotationDetectOutN)
    else $error("rotation not flagged above maximum threshold");
  a_rotate_stop: assert property (motorSpeed == 12'h000 |-> ##2 rotationDetectOutN)
    else $error("rotation flagged at standstill");
  a_excite_off: assert property (!motorExcited |-> ##2 excitationOutN)
    else $error("excitation shown while unexcited");
  a_ot_clear: assert property (noProhibit |=> !overtravelOutN)
    else $error("overtravel shown without prohibit");
  a_contact_off: assert property (torqueHeld |=> !contactModeSwitch)
    else $error("contact switch with torque limit active");
endmodule
bind sso_sequence_outputs sso_checker CHK (.clock, .resetn, .fwdTorqueLimitInN,
  .fwdProhibitInN, .revProhibitInN, .faultDetect, .motorSpeed, .mainPowerOk,
  .motorExcited, .faultOut, .rotationDetectOutN, .readyOutN, .overtravelOutN,
  .excitationOutN, .contactModeSwitch);
`default_nettype wire

// *** tb/sso_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sso_host_model
  import sso_pkg::*;
(
  input  wire logic        powerSwitch,
  input  wire logic        cutOnFault,
  input  wire logic [11:0] speedReq,
  input  wire logic        faultOut,
  input  wire logic        overtravelOutN,
  output var  logic        mainPowerOk,
  output var  logic [11:0] motorSpeed
);
  // supply contactor opens on fault when wired that way
  assign mainPowerOk = powerSwitch & ~(cutOnFault & faultOut);
  // no motion reference while travel is blocked
  assign motorSpeed = overtravelOutN ? 12'h000 : speedReq;
endmodule
`default_nettype wire

// *** tb/sso_sequence_outputs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, a) begin check_count++; if ((a) !== (x)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, (x), (a)); end end
module sso_sequence_outputs_tb
  import sso_pkg::*;
;
  logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, e, irq, faultOut, readyOutN, indexPulseOutN;
  logic        fwdTorqueLimitInN = 1, revTorqueLimitInN = 1, faultClearInN = 1;
  logic        fwdProhibitInN = 1, revProhibitInN = 1, servoOnInN = 1;
  logic        indexPositionInN = 1, faultDetect = 0, prepDone = 0, motorExcited = 0;
  logic        powerSwitch = 0, cutOnFault = 0, mainPowerOk, rotationDetectOutN;
  logic        overtravelOutN, excitationOutN, contactModeSwitch;
  logic [11:0] speedReq = 0, motorSpeed;
  logic [2:0]  termOutN;
  int          seed = 32'h1006AAD5, err_count = 0, check_count = 0, cyc = 0, th, sp, c;

  sso_sequence_outputs DUT (.*);
  sso_host_model HOST (.*);

  always #2 clock = ~clock;

  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic isWr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= isWr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", x, q)
  endtask

  // fault cause is removed before anyone clears it
  task automatic pulseFault();
    faultDetect <= 1'b1;
    w(2);
    faultDetect <= 1'b0;
    w(4);
  endtask

  initial begin
    w(6);
    resetn <= 1'b1;
    rdc(SSO_THRESH_OFS, 32'h14);
    rdc(SSO_ASSIGN_OFS, 32'h210);
    rdc(SSO_LIMCFG_OFS, 32'h0);
    rdc(SSO_IRQEN_OFS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, e)
    // fault latch: pin clear, panel clear, power-up clear
    wr(SSO_IRQEN_OFS, 32'h1);
    pulseFault();
    `CHK("fault", 1'b1, faultOut)
    `CHK("irq", 1'b1, irq)
    rdc(SSO_IRQSTAT_OFS, 32'h1);
    faultClearInN <= 1'b0;
    w(6);
    `CHK("fault", 1'b0, faultOut)
    faultClearInN <= 1'b1;
    wr(SSO_IRQCLR_OFS, 32'h1);
    w(2);
    `CHK("irq", 1'b0, irq)
    pulseFault();
    wr(SSO_IRQEN_OFS, 32'h0);
    w(2);
    `CHK("irq", 1'b0, irq)
    wr(SSO_CTRL_OFS, 32'h1);
    w(4);
    `CHK("fault", 1'b0, faultOut)
    pulseFault();
    resetn <= 1'b0;
    w(2);
    resetn <= 1'b1;
    w(2);
    `CHK("fault", 1'b0, faultOut)
    // random thresholds and speeds; over-range writes clamp
    for (int i = 0; i < 10; i++) begin
      th = $unsigned($random(seed)) % 4000;
      sp = $unsigned($random(seed)) % 4096;
      wr(SSO_THRESH_OFS, th);
      speedReq <= sp[11:0];
      w(4);
      if (th > 3000) th = 3000;
      rdc(SSO_THRESH_OFS, th);
      `CHK("rotate", sp <= th, rotationDetectOutN)
      rdc(SSO_STATUS_OFS, (sp > th) ? 32'h2 : 32'h0);
    end
    speedReq <= 12'h000;
    // every mix of servo-on, preparation and power
    for (int i = 0; i < 8; i++) begin
      servoOnInN <= ~i[0];
      prepDone <= i[1];
      powerSwitch <= i[2];
      motorExcited <= i[1];
      w(6);
      `CHK("ready", i != 7, readyOutN)
      `CHK("term", {i != 7, 2'b11}, termOutN)
      `CHK("excite", !(i[0] && i[1]), excitationOutN)
    end
    cutOnFault <= 1'b1;
    pulseFault();
    `CHK("ready", 1'b1, readyOutN)
    wr(SSO_CTRL_OFS, 32'h1);
    w(6);
    `CHK("ready", 1'b0, readyOutN)
    wr(SSO_ASSIGN_OFS, 32'h215);
    indexPositionInN <= 1'b0;
    w(6);
    `CHK("index", 1'b0, indexPulseOutN)
    `CHK("term", 1'b0, termOutN[0])
    indexPositionInN <= 1'b1;
    w(6);
    `CHK("term", 1'b1, termOutN[0])
    // pending limit config waits for restart
    wr(SSO_LIMCFG_OFS, 32'h6);
    fwdProhibitInN <= 1'b0;
    w(6);
    `CHK("ot", 1'b1, overtravelOutN)
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 6 : (k == 1) ? 4 : 0;
      wr(SSO_LIMCFG_OFS, c);
      wr(SSO_CTRL_OFS, 32'h2);
      rdc(SSO_LIMCFG_OFS, c * 17);
      for (int j = 0; j < 4; j++) begin
        fwdProhibitInN <= j[0];
        revProhibitInN <= j[1];
        w(6);
        `CHK("ot", (!j[0] && !c[1]) || (!j[1] && !c[2]), overtravelOutN)
      end
    end
    for (int m = 0; m < 9; m++) begin
      wr(SSO_CTRL_OFS, m << 4);
      for (int j = 0; j < 4; j++) begin
        fwdTorqueLimitInN <= j[0];
        revTorqueLimitInN <= j[1];
        w(6);
        `CHK("contact", m > 3 && m < 7 && j == 3, contactModeSwitch)
      end
    end
    conclude();
  end
endmodule
`default_nettype wire

// *** verilog/sso_pkg.sv ***
package sso_pkg;

  // register byte offsets
  localparam logic [7:0] SSO_CTRL_OFS     = 8'h00;
  localparam logic [7:0] SSO_THRESH_OFS   = 8'h04;
  localparam logic [7:0] SSO_LIMCFG_OFS   = 8'h08;
  localparam logic [7:0] SSO_ASSIGN_OFS   = 8'h0C;
  localparam logic [7:0] SSO_STATUS_OFS   = 8'h10;
  localparam logic [7:0] SSO_IRQSTAT_OFS  = 8'h14;
  localparam logic [7:0] SSO_IRQCLR_OFS   = 8'h18;
  localparam logic [7:0] SSO_IRQEN_OFS    = 8'h1C;

  // control register fields
  localparam int SSO_CTRL_CLEAR_BIT   = 0;
  localparam int SSO_CTRL_RESTART_BIT = 1;
  localparam int SSO_CTRL_MODE_LSB    = 4;
  localparam int SSO_MODE_W           = 4;

  // mode combinations that use contact speed, then the reset mode
  localparam logic [3:0] SSO_MODE_CONTACT_A = 4'h4;
  localparam logic [3:0] SSO_MODE_CONTACT_B = 4'h5;
  localparam logic [3:0] SSO_MODE_CONTACT_C = 4'h6;
  localparam logic [3:0] SSO_MODE_RST       = 4'h0;

  // speed threshold in rpm
  localparam int         SSO_SPEED_W       = 12;
  localparam logic [11:0] SSO_THRESH_MAX   = 12'hBB8; // 3000
  localparam logic [11:0] SSO_THRESH_RST   = 12'h014; // 20

  // limit config, one bit per decimal digit
  localparam logic [3:0] SSO_LIMCFG_RST    = 4'h0;
  localparam int         SSO_LIM_FWD_BIT   = 1;
  localparam int         SSO_LIM_REV_BIT   = 2;

  // output assignment: one nibble per terminal
  localparam int          SSO_TERMS        = 3;
  localparam logic [11:0] SSO_ASSIGN_RST   = 12'h210;
  localparam logic [3:0]  SSO_SEL_ROTATE   = 4'h1;
  localparam logic [3:0]  SSO_SEL_READY    = 4'h2;
  localparam logic [3:0]  SSO_SEL_INDEX    = 4'h5;
  localparam logic [3:0]  SSO_SEL_OVERTRV  = 4'h6;
  localparam logic [3:0]  SSO_SEL_EXCITE   = 4'h7;

  // synchronised pin inputs, all active low at the pin
  typedef struct packed {
    logic fwdTorqueLimitN;
    logic revTorqueLimitN;
    logic faultClearN;
    logic fwdProhibitN;
    logic revProhibitN;
    logic servoOnN;
    logic indexPosN;
  } sso_pins_t;

  localparam sso_pins_t SSO_PINS_IDLE = 7'h7F;

  // internal status, active high; also the interrupt layout
  typedef struct packed {
    logic contactSwitch;
    logic excited;
    logic overtravel;
    logic ready;
    logic rotating;
    logic fault;
  } sso_status_t;

  localparam int SSO_STAT_W = 6;

endpackage

// *** verilog/sso_sequence_outputs.sv ***
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sso_sequence_outputs
  import sso_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // sequence pins, active low
  input  wire logic                   fwdTorqueLimitInN,
  input  wire logic                   revTorqueLimitInN,
  input  wire logic                   faultClearInN,
  input  wire logic                   fwdProhibitInN,
  input  wire logic                   revProhibitInN,
  input  wire logic                   servoOnInN,
  input  wire logic                   indexPositionInN,
  // drive internals, same clock
  input  wire logic                   faultDetect,
  input  wire logic [SSO_SPEED_W-1:0] motorSpeed,
  input  wire logic                   prepDone,
  input  wire logic                   mainPowerOk,
  input  wire logic                   motorExcited,
  // outputs
  output var  logic                   faultOut,
  output var  logic                   rotationDetectOutN,
  output var  logic                   readyOutN,
  output var  logic                   indexPulseOutN,
  output var  logic                   overtravelOutN,
  output var  logic                   excitationOutN,
  output var  logic [SSO_TERMS-1:0]   termOutN,
  output var  logic                   contactModeSwitch,
  output var  logic                   irq
);

  sso_pins_t   pinMeta_r;
  sso_pins_t   pin_r;
  sso_status_t stat;
  sso_status_t statPrev_r;
  sso_status_t irqStat_r;
  sso_status_t irqEn_r;
  sso_status_t irqSet;

  logic                    faultLatch_r;
  logic                    rotating_r;
  logic                    ready_r;
  logic                    overtravel_r;
  logic                    excited_r;
  logic                    contact_r;
  logic [SSO_MODE_W-1:0]   modeSel_r;
  logic [SSO_SPEED_W-1:0]  thresh_r;
  logic [3:0]              limCfgPend_r;
  logic [3:0]              limCfgAct_r;
  logic [4*SSO_TERMS-1:0]  assign_r;
  logic                    panelClear_r;
  logic                    restart_r;

  logic                    wrEn;
  logic                    rdSetup;
  logic                    addrOk;
  logic                    clearReq;
  logic                    fwdProhibit;
  logic                    revProhibit;
  logic                    modeIsContact;
  logic [SSO_SPEED_W-1:0]  wrThresh;
  logic [31:0]             rdData;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinMeta_r <= SSO_PINS_IDLE;
      pin_r     <= SSO_PINS_IDLE;
    end else begin
      pinMeta_r <= {fwdTorqueLimitInN, revTorqueLimitInN, faultClearInN,
                    fwdProhibitInN, revProhibitInN, servoOnInN,
                    indexPositionInN};
      pin_r     <= pinMeta_r;
    end
  end

  // apb decode: zero wait states, every access finishes in one access cycle
  always_comb begin
    addrOk = (paddr[1:0] == 2'b00) && (paddr <= SSO_IRQEN_OFS);
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign wrEn    = psel && penable && pwrite && addrOk;
  assign rdSetup = psel && !penable && !pwrite;

  // clamp oversize threshold writes to the top of the range
  always_comb begin
    if (pwdata[31:SSO_SPEED_W] != 20'h00000 ||
        pwdata[SSO_SPEED_W-1:0] > SSO_THRESH_MAX) begin
      wrThresh = SSO_THRESH_MAX;
    end else begin
      wrThresh = pwdata[SSO_SPEED_W-1:0];
    end
  end

  // configuration registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      modeSel_r    <= SSO_MODE_RST;
      thresh_r     <= SSO_THRESH_RST;
      limCfgPend_r <= SSO_LIMCFG_RST;
      assign_r     <= SSO_ASSIGN_RST;
    end else if (wrEn) begin
      unique case (paddr)
        SSO_CTRL_OFS: begin
          modeSel_r <= pwdata[SSO_CTRL_MODE_LSB +: SSO_MODE_W];
        end
        SSO_THRESH_OFS: begin
          thresh_r <= wrThresh;
        end
        SSO_LIMCFG_OFS: begin
          limCfgPend_r <= pwdata[3:0];
        end
        SSO_ASSIGN_OFS: begin
          assign_r <= pwdata[4*SSO_TERMS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // one-cycle command pulses from the control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      panelClear_r <= 1'b0;
      restart_r    <= 1'b0;
    end else begin
      panelClear_r <= wrEn && (paddr == SSO_CTRL_OFS) && pwdata[SSO_CTRL_CLEAR_BIT];
      restart_r    <= wrEn && (paddr == SSO_CTRL_OFS) && pwdata[SSO_CTRL_RESTART_BIT];
    end
  end

  // limit config only takes hold on a restart, whether or not the motor is moving
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      limCfgAct_r <= SSO_LIMCFG_RST;
    end else if (restart_r) begin
      limCfgAct_r <= limCfgPend_r;
    end
  end

  // fault latch; a live fault beats any clear request
  assign clearReq = !pin_r.faultClearN || panelClear_r || restart_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      faultLatch_r <= 1'b0;
    end else if (faultDetect) begin
      faultLatch_r <= 1'b1;
    end else if (clearReq) begin
      faultLatch_r <= 1'b0;
    end
  end

  // prohibit inputs, masked by the active limit config
  assign fwdProhibit = !pin_r.fwdProhibitN && !limCfgAct_r[SSO_LIM_FWD_BIT];
  assign revProhibit = !pin_r.revProhibitN && !limCfgAct_r[SSO_LIM_REV_BIT];

  always_comb begin
    modeIsContact = (modeSel_r == SSO_MODE_CONTACT_A) ||
                    (modeSel_r == SSO_MODE_CONTACT_B) ||
                    (modeSel_r == SSO_MODE_CONTACT_C);
  end

  // rotation flag; a new threshold counts from the next cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rotating_r <= 1'b0;
    end else begin
      rotating_r <= motorSpeed > thresh_r;
    end
  end

  // ready flag; a latched fault or lost power drops it on the next cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= !pin_r.servoOnN && prepDone &&
                 !faultLatch_r && mainPowerOk;
    end
  end

  // overtravel flag, high while an unmasked prohibit is seen
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overtravel_r <= 1'b0;
    end else begin
      overtravel_r <= fwdProhibit || revProhibit;
    end
  end

  // excitation needs both the command and the power stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      excited_r <= 1'b0;
    end else begin
      excited_r <= !pin_r.servoOnN && motorExcited;
    end
  end

  // contact-speed switch; both torque pins must be released
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      contact_r <= 1'b0;
    end else begin
      contact_r <= modeIsContact && pin_r.fwdTorqueLimitN &&
                   pin_r.revTorqueLimitN;
    end
  end

  assign stat = '{contactSwitch: contact_r, excited: excited_r,
                  overtravel: overtravel_r, ready: ready_r,
                  rotating: rotating_r, fault: faultLatch_r};

  // fault pin low in normal running, high while latched
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      faultOut <= 1'b0;
    end else begin
      faultOut <= faultLatch_r;
    end
  end

  // rotation pin, low while turning faster than the threshold
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rotationDetectOutN <= 1'b1;
    end else begin
      rotationDetectOutN <= !rotating_r;
    end
  end

  // ready pin, low only when every condition is met
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readyOutN <= 1'b1;
    end else begin
      readyOutN <= !ready_r;
    end
  end

  // index pin; width follows the time spent at the mark
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      indexPulseOutN <= 1'b1;
    end else begin
      indexPulseOutN <= pin_r.indexPosN;
    end
  end

  // overtravel pin, high while travel is blocked
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overtravelOutN <= 1'b0;
    end else begin
      overtravelOutN <= overtravel_r;
    end
  end

  // excitation pin, low while enabled and excited
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      excitationOutN <= 1'b1;
    end else begin
      excitationOutN <= !excited_r;
    end
  end

  // mode switch request towards the control loops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      contactModeSwitch <= 1'b0;
    end else begin
      contactModeSwitch <= contact_r;
    end
  end

  // terminal multiplexer; unmodelled selections rest high
  for (genvar t = 0; t < SSO_TERMS; t++) begin : gTerm
    logic [3:0] sel;
    assign sel = assign_r[4*t +: 4];
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        termOutN[t] <= 1'b1;
      end else begin
        unique case (sel)
          SSO_SEL_ROTATE:  termOutN[t] <= !rotating_r;
          SSO_SEL_READY:   termOutN[t] <= !ready_r;
          SSO_SEL_INDEX:   termOutN[t] <= pin_r.indexPosN;
          SSO_SEL_OVERTRV: termOutN[t] <= overtravel_r;
          SSO_SEL_EXCITE:  termOutN[t] <= !excited_r;
          default:         termOutN[t] <= 1'b1;
        endcase
      end
    end
  end

  // interrupt events are rising edges of the status flags
  assign irqSet = stat & ~statPrev_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      statPrev_r <= '0;
    end else begin
      statPrev_r <= stat;
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= '0;
    end else if (wrEn && paddr == SSO_IRQCLR_OFS) begin
      irqStat_r <= (irqStat_r & ~pwdata[SSO_STAT_W-1:0]) | irqSet;
    end else begin
      irqStat_r <= irqStat_r | irqSet;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqEn_r <= '0;
    end else if (wrEn && paddr == SSO_IRQEN_OFS) begin
      irqEn_r <= pwdata[SSO_STAT_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqEn_r);
    end
  end

  // read mux; data is registered during setup for the access cycle
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (paddr)
      SSO_CTRL_OFS: begin
        rdData[SSO_CTRL_MODE_LSB +: SSO_MODE_W] = modeSel_r;
      end
      SSO_THRESH_OFS:  rdData[SSO_SPEED_W-1:0] = thresh_r;
      SSO_LIMCFG_OFS:  rdData[7:0] = {limCfgAct_r, limCfgPend_r};
      SSO_ASSIGN_OFS:  rdData[4*SSO_TERMS-1:0] = assign_r;
      SSO_STATUS_OFS:  rdData[SSO_STAT_W-1:0] = stat;
      SSO_IRQSTAT_OFS: rdData[SSO_STAT_W-1:0] = irqStat_r;
      SSO_IRQEN_OFS:   rdData[SSO_STAT_W-1:0] = irqEn_r;
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= rdData;
    end
  end

endmodule
`default_nettype wire
